// ### verilog/afbi_pkg.sv
// package for the flash bus host controller: register map, timing, state types
// assumes a 125 MHz hclk and a single AHB-Lite master in front of the controller
package afbi_pkg;
    localparam int unsigned clk_mhz = 125;
    // reset low pulse and its shortened form when the flash is idle
    localparam int unsigned reset_low_pulse_time_us = 25;
    localparam int unsigned reset_low_short_time_ns = 100;
    localparam int unsigned reset_low_cycles = reset_low_pulse_time_us * clk_mhz;
    localparam int unsigned reset_short_cycles = (reset_low_short_time_ns * clk_mhz + 999) / 1000;
    // device internal reset completion after release during a busy operation
    localparam int unsigned reset_complete_time_ns = 100;
    localparam int unsigned reset_complete_cycles =
        (reset_complete_time_ns * clk_mhz + 999) / 1000;
    // register offsets (byte addresses)
    localparam logic [7:0] reg_ctrl = 8'h00;
    localparam logic [7:0] reg_addr = 8'h04;
    localparam logic [7:0] reg_wdata = 8'h08;
    localparam logic [7:0] reg_rdata = 8'h0C;
    localparam logic [7:0] reg_status = 8'h10;
    localparam logic [7:0] reg_cmd = 8'h14;
    localparam logic [7:0] reg_wakeup = 8'h18;
    // control register fields
    localparam int unsigned ctrl_byte_mode = 0;
    localparam int unsigned ctrl_sel2 = 1;
    localparam int unsigned ctrl_prog_en = 2;
    localparam int unsigned ctrl_short_reset = 3;
    // command codes written to the command register
    localparam logic [2:0] cmd_read = 3'h1;
    localparam logic [2:0] cmd_write = 3'h2;
    localparam logic [2:0] cmd_reset = 3'h3;
    localparam logic [2:0] cmd_set_config = 3'h4;
    // configuration sequence and read-array command data words
    localparam logic [15:0] cfg_setup_data = 16'h0060;
    localparam logic [15:0] cfg_confirm_data = 16'h0004;
    localparam logic [15:0] read_array_data = 16'h00FF;
    // bus cycle phase lengths and the default wake-up wait, in clock cycles
    localparam logic [15:0] access_cycles = 16'h000E;
    localparam logic [15:0] strobe_cycles = 16'h0008;
    localparam logic [15:0] recovery_cycles = 16'h0005;
    localparam logic [15:0] wakeup_default = 16'h0020;
    localparam int unsigned addr_w = 24;

    typedef enum logic [6:0] {
        st_idle = 7'h01,
        st_setup = 7'h02,
        st_strobe = 7'h04,
        st_recover = 7'h08,
        st_reset_low = 7'h10,
        st_wake = 7'h20,
        st_cfg2 = 7'h40
    } afbi_state_type;

    // flash pins driven by the controller
    typedef struct packed {
        logic power_down_reset_in_n;
        logic select_in_0;
        logic select_in_1;
        logic select_in_2;
        logic oe_n;
        logic we_n;
        logic byte_n;
        logic program_enable_input;
        logic [addr_w-1:0] addr;
        logic [15:0] dq_out;
        logic [15:0] dq_oe;
    } afbi_pins_type;

    typedef struct packed {
        afbi_state_type state;
        logic [31:0] count;
        logic is_write;
        logic [7:0] ctrl;
        logic [addr_w-1:0] addr;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic [15:0] wakeup;
        logic done;
        logic cfg_mode;
        logic eight_word;
        logic [15:0] cfg_value;
        afbi_pins_type pins;
        logic hsel_d;
        logic hwrite_d;
        logic [7:0] haddr_d;
        logic [31:0] hrdata;
    } afbi_regs_type;
endpackage

// ### verilog/afbi_host.sv
// host controller for an asynchronous parallel flash port, driven over AHB-Lite
// assumes the flash pins settle within the programmed phase counts; busy and dq sync here
//
// Summary of operation
// - hold reset low at least 25 us
// - idle flash allows 100 ns reset pulse
// - wait wake-up after later of reset, busy
// - read asserts select and oe, we high
// - never assert oe and we together
// - array write raises program enable; here only when the ctrl_prog_en bit is set
// - read-array command before page reads
// - config set by 0060h then 0004h
module afbi_host
    import afbi_pkg::*;
#(
    parameter int unsigned reset_cycles = reset_low_cycles
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // flash pins
    output afbi_pins_type flash_out,
    input wire logic [15:0] dq_in,
    input wire logic busy_status_out
);
    afbi_regs_type r, next_r;
    logic [15:0] dq_s1, dq_s2;
    logic busy_s1, busy_s2;
    logic ce_decoded;
    logic [31:0] reset_len;

    // two-stage synchronisers on the flash outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dq_s1 <= 16'h0000;
            dq_s2 <= 16'h0000;
            busy_s1 <= 1'b1;
            busy_s2 <= 1'b1;
        end else begin
            dq_s1 <= dq_in;
            dq_s2 <= dq_s1;
            busy_s1 <= busy_status_out;
            busy_s2 <= busy_s1;
        end
    end

    // enabled select pattern for current pins
    assign ce_decoded = r.pins.select_in_2 ? !(r.pins.select_in_1 && r.pins.select_in_0)
                                           : !(r.pins.select_in_1 || r.pins.select_in_0);
    assign reset_len = r.ctrl[ctrl_short_reset] && busy_s2 ? 32'(reset_short_cycles)
                                                           : 32'(reset_cycles);

    always_comb begin
        next_r = r;
        // ahb data phase, single cycle answer
        next_r.hsel_d = hsel && hready && htrans[1];
        next_r.hwrite_d = hwrite;
        next_r.haddr_d = haddr[7:0];
        if (hsel && hready && htrans[1] && !hwrite) begin
            case (haddr[7:0])
                reg_ctrl: next_r.hrdata = {24'h000000, r.ctrl};
                reg_addr: next_r.hrdata = {8'h00, r.addr};
                reg_wdata: next_r.hrdata = {16'h0000, r.wdata};
                reg_rdata: next_r.hrdata = {16'h0000, r.rdata};
                reg_status: next_r.hrdata = {12'h000, r.cfg_value, r.eight_word, busy_s2,
                                             r.done, r.state == st_idle ? 1'b0 : 1'b1};
                reg_wakeup: next_r.hrdata = {16'h0000, r.wakeup};
                default: next_r.hrdata = 32'h00000000;
            endcase
        end
        if (r.hsel_d && r.hwrite_d) begin
            case (r.haddr_d)
                reg_ctrl: next_r.ctrl = hwdata[7:0];
                reg_addr: next_r.addr = hwdata[addr_w-1:0];
                reg_wdata: next_r.wdata = hwdata[15:0];
                reg_wakeup: next_r.wakeup = hwdata[15:0];
                default: ;
            endcase
        end
        // pins that follow control settings
        next_r.pins.byte_n = !r.ctrl[ctrl_byte_mode];
        case (r.state)
            st_idle: begin
                if (r.hsel_d && r.hwrite_d && r.haddr_d == reg_cmd && hwdata[2:0] != 3'h0) begin
                    next_r.done = 1'b0;
                    next_r.count = 32'h0;
                    next_r.cfg_mode = 1'b0;
                    next_r.is_write = 1'b1;
                    next_r.pins.addr = r.addr;
                    next_r.pins.dq_out = r.wdata;
                    next_r.state = st_setup;
                    case (hwdata[2:0])
                        cmd_read: begin
                            // read-array command cycle first, the array read follows it
                            next_r.cfg_mode = 1'b1;
                            next_r.pins.dq_out = read_array_data;
                        end
                        cmd_write: next_r.pins.program_enable_input = r.ctrl[ctrl_prog_en];
                        cmd_reset: begin
                            next_r.state = st_reset_low;
                            next_r.pins.power_down_reset_in_n = 1'b0;
                            next_r.pins.dq_oe = 16'h0000;
                        end
                        cmd_set_config: begin
                            next_r.cfg_mode = 1'b1;
                            next_r.cfg_value = r.wdata;
                            next_r.pins.addr = {8'h00, r.wdata};
                            next_r.pins.dq_out = cfg_setup_data;
                        end
                        default: next_r.state = st_idle;
                    endcase
                    if (next_r.state == st_setup) begin
                        // select asserted by the ce pattern the control register asks for
                        next_r.pins.select_in_2 = r.ctrl[ctrl_sel2];
                        next_r.pins.select_in_1 = 1'b0;
                        next_r.pins.select_in_0 = r.ctrl[ctrl_sel2];
                        next_r.pins.dq_oe = next_r.is_write ? 16'hFFFF : 16'h0000;
                    end
                end
            end
            st_setup: begin
                // we or oe, never both
                next_r.pins.oe_n = r.is_write;
                next_r.pins.we_n = !r.is_write;
                next_r.count = 32'h0;
                next_r.state = st_strobe;
            end
            st_strobe: begin
                next_r.count = r.count + 32'h1;
                if (r.count >= 32'(r.is_write ? strobe_cycles : access_cycles)) begin
                    if (!r.is_write) next_r.rdata = r.ctrl[ctrl_byte_mode] ?
                        {8'h00, dq_s2[7:0]} : dq_s2;
                    next_r.pins.oe_n = 1'b1;
                    next_r.pins.we_n = 1'b1;
                    next_r.count = 32'h0;
                    next_r.state = st_recover;
                end
            end
            st_recover: begin
                next_r.count = r.count + 32'h1;
                next_r.pins.select_in_0 = 1'b1;
                next_r.pins.select_in_1 = 1'b1;
                next_r.pins.select_in_2 = 1'b1;
                if (r.count >= 32'(recovery_cycles)) begin
                    next_r.pins.dq_oe = 16'h0000;
                    next_r.pins.program_enable_input = 1'b0;
                    if (r.cfg_mode) begin
                        next_r.state = st_cfg2;
                    end else begin
                        next_r.done = 1'b1;
                        next_r.state = st_idle;
                    end
                end
            end
            st_cfg2: begin
                // second cycle: array read after read-array, or config confirm
                next_r.cfg_mode = 1'b0;
                if (r.pins.dq_out == read_array_data) begin
                    next_r.is_write = 1'b0;
                end else begin
                    // confirm repeats value on address lines, eight-word bit is 13
                    next_r.eight_word = r.cfg_value[13];
                    next_r.pins.dq_out = cfg_confirm_data;
                    next_r.pins.dq_oe = 16'hFFFF;
                end
                next_r.pins.select_in_2 = r.ctrl[ctrl_sel2];
                next_r.pins.select_in_1 = 1'b0;
                next_r.pins.select_in_0 = r.ctrl[ctrl_sel2];
                next_r.state = st_setup;
            end
            st_reset_low: begin
                next_r.count = r.count + 32'h1;
                if (r.count + 32'h1 >= reset_len) begin
                    next_r.pins.power_down_reset_in_n = 1'b1;
                    next_r.eight_word = 1'b0;
                    next_r.count = 32'h0;
                    next_r.state = st_wake;
                end
            end
            st_wake: begin
                // wake-up counted from later of reset release and busy high
                if (!busy_s2) next_r.count = 32'h0;
                else next_r.count = r.count + 32'h1;
                if (busy_s2 && r.count >= {16'h0000, r.wakeup}) begin
                    next_r.done = 1'b1;
                    next_r.state = st_idle;
                end
            end
            default: next_r.state = st_idle;
        endcase
        if (ce_decoded && !r.pins.oe_n && !r.pins.we_n) next_r.pins.we_n = 1'b1;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= '0;
            r.state <= st_idle;
            r.wakeup <= wakeup_default;
            r.pins.power_down_reset_in_n <= 1'b1;
            r.pins.select_in_0 <= 1'b1;
            r.pins.select_in_1 <= 1'b1;
            r.pins.select_in_2 <= 1'b1;
            r.pins.oe_n <= 1'b1;
            r.pins.we_n <= 1'b1;
            r.pins.byte_n <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // outputs straight from registers, ready and response tied to constants
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = r.hrdata;
    assign flash_out = r.pins;
endmodule

// ### tb/afbi_host_chk.sv
// checker for the flash host: pin protocol at the top ports
// bound to afbi_host below; sees only its ports
module afbi_host_chk
    import afbi_pkg::*;
#(
    parameter int unsigned reset_cycles = 10
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb side
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // flash side
    input wire afbi_pins_type flash_out,
    input wire logic [15:0] dq_in,
    input wire logic busy_status_out
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned min_low = reset_cycles < reset_short_cycles ?
        reset_cycles : reset_short_cycles;
    logic [31:0] low_cnt;
    logic [15:0] cfg_addr;
    logic en;
    // decoded enable from the three selects
    assign en = flash_out.select_in_2 ? !(flash_out.select_in_0 & flash_out.select_in_1) :
        !(flash_out.select_in_0 | flash_out.select_in_1);
    // reset pin low time and the config setup address
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            low_cnt <= '0;
            cfg_addr <= '0;
        end else begin
            low_cnt <= flash_out.power_down_reset_in_n ? 32'h0 : low_cnt + 32'h1;
            if (!flash_out.we_n && flash_out.dq_out == 16'h0060) begin
                cfg_addr <= flash_out.addr[15:0];
            end
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    AST_RESET_LOW: assert property (
        $rose(flash_out.power_down_reset_in_n) |-> low_cnt >= min_low)
        else $error("reset pin pulse too short");
    AST_WAKE_WAIT: assert property (
        $rose(flash_out.power_down_reset_in_n) |-> (flash_out.oe_n && flash_out.we_n)[*8])
        else $error("strobe inside wake-up time");
    AST_READ_CTRL: assert property (
        !flash_out.oe_n |-> flash_out.power_down_reset_in_n && flash_out.we_n && en)
        else $error("read strobe with bad controls");
    AST_READ_FREE: assert property (
        !flash_out.oe_n |-> flash_out.dq_oe == 16'h0000)
        else $error("host drives data during read");
    AST_OE_WE_EXCL: assert property (
        !(!flash_out.oe_n && !flash_out.we_n))
        else $error("both strobes low");
    AST_WRITE_SEL: assert property (
        !flash_out.we_n |-> en && flash_out.power_down_reset_in_n)
        else $error("write strobe while disabled");
    AST_WRITE_HOLD: assert property (
        !flash_out.we_n && $past(!flash_out.we_n) |-> $stable(flash_out.dq_out)
            && $stable(flash_out.addr) && flash_out.dq_oe[7:0] == 8'hFF)
        else $error("write data or address moved");
    AST_CFG_PAIR: assert property (
        $fell(flash_out.we_n) && flash_out.dq_out == 16'h0060 |-> ##[1:300]
            ($fell(flash_out.we_n) && flash_out.dq_out == 16'h0004
            && flash_out.addr[15:0] == cfg_addr))
        else $error("config confirm missing or wrong");
    COV_READ: cover property ($fell(flash_out.oe_n));
    COV_WRITE: cover property ($fell(flash_out.we_n) && flash_out.program_enable_input);
    COV_RESET: cover property ($rose(flash_out.power_down_reset_in_n));
endmodule

bind afbi_host afbi_host_chk #(.reset_cycles(reset_cycles)) afbi_host_chk_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .flash_out(flash_out),
    .dq_in(dq_in), .busy_status_out(busy_status_out));

// ### tb/afbi_flash_model.sv
// behavioural flash part on the far side of the host pins
// sees the host pin struct; drives the merged data bus and busy pin
module afbi_flash_model
    import afbi_pkg::*;
(
    // host pins
    input wire afbi_pins_type pins,
    // back to the host
    output logic [15:0] dq_in,
    output logic busy_status_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [16];
    logic [15:0] enhanced_config_reg;
    logic [15:0] last_dq;
    logic cfg_pend;
    logic arr_mode;
    logic en;
    logic rd;
    logic [15:0] word;
    logic [15:0] rv;
    // decode, read gating and the addressed word
    assign en = pins.select_in_2 ? !(pins.select_in_0 & pins.select_in_1) :
        !(pins.select_in_0 | pins.select_in_1);
    assign rd = pins.power_down_reset_in_n && en && !pins.oe_n;
    // no page buffer: every read in array mode senses the array, status word outside array mode
    assign word = arr_mode ? mem[pins.addr[4:1]] : 16'h0080;
    assign rv = pins.byte_n ? word : {~last_dq[15:8], pins.addr[0] ? word[15:8] : word[7:0]};
    // merged bus: host, then flash, else inverse of the last read
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            dq_in[i] = pins.dq_oe[i] ? pins.dq_out[i] : (rd ? rv[i] : ~last_dq[i]);
        end
    end
    initial begin
        for (int i = 0; i < 16; i++) begin
            mem[i] = 16'hC0A0 ^ 16'(i);
        end
        busy_status_out = 1'b1;
        enhanced_config_reg = 16'h0000;
        cfg_pend = 1'b0;
        arr_mode = 1'b1;
        last_dq = 16'h0000;
    end
    // remember what was last driven
    always @(posedge pins.oe_n) last_dq = word;
    // commands and data latch at the rising write strobe
    always @(posedge pins.we_n) begin
        if (pins.power_down_reset_in_n && en && pins.oe_n) begin
            if (pins.dq_out == read_array_data) begin
                arr_mode = 1'b1;
            end else if (pins.dq_out == cfg_setup_data) begin
                cfg_pend = 1'b1;
                arr_mode = 1'b0;
            end else if (cfg_pend && pins.dq_out == cfg_confirm_data) begin
                enhanced_config_reg = pins.addr[15:0];
                cfg_pend = 1'b0;
                arr_mode = 1'b1;
            end else begin
                // any other write leaves array mode until read-array comes
                arr_mode = 1'b0;
                if (pins.program_enable_input) begin
                    mem[pins.addr[4:1]] = pins.dq_out;
                    busy_status_out = 1'b0;
                    #300 busy_status_out = 1'b1;
                end
            end
        end
    end
    // power-down clears volatile state and releases busy
    always @(negedge pins.power_down_reset_in_n) begin
        busy_status_out = 1'b1;
        enhanced_config_reg = 16'h0000;
        cfg_pend = 1'b0;
        arr_mode = 1'b1;
    end
endmodule

// ### tb/tb.sv
// self-checking bench for the flash host over ahb-lite
// a flash model sits on the pins; the checker is bound in
module tb
    import afbi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, busy_status_out;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata;
    logic [15:0] dq_in;
    afbi_pins_type flash_out;
    int err_total = 0;
    int total_checks = 0;
    afbi_host #(.reset_cycles(10)) afbi_host_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .flash_out(flash_out),
        .dq_in(dq_in), .busy_status_out(busy_status_out));
    afbi_flash_model afbi_flash_model_inst (
        .pins(flash_out), .dq_in(dq_in), .busy_status_out(busy_status_out));
    // clock
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // one single ahb transfer, read data taken at the data phase edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    // issue a command and wait for done, idle and a ready pin
    task automatic op(input logic [2:0] c, input logic [23:0] a, input logic [15:0] d);
        logic [31:0] q;
        bus(1'b1, reg_addr, {8'h0, a}, q);
        bus(1'b1, reg_wdata, {16'h0, d}, q);
        bus(1'b1, reg_cmd, {29'h0, c}, q);
        q = '0;
        while (q[2:0] !== 3'b110) bus(1'b0, reg_status, 32'h0, q);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // watchdog
    initial begin
        #200000;
        err_total++;
        test_done();
    end
    initial begin
        logic [31:0] q;
        hresetn = 1'b0;
        hsel = 1'b0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        haddr = '0;
        hwdata = '0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        // reset values and an unmapped read
        bus(1'b0, reg_ctrl, 32'h0, q);
        check(q, 32'h0);
        bus(1'b0, reg_wakeup, 32'h0, q);
        check(q, {16'h0, wakeup_default});
        bus(1'b0, 8'h40, 32'h0, q);
        check(q, 32'h0);
        $display("test registers done");
        // full reset pulse, then a write with programming locked
        op(cmd_reset, 24'h0, 16'h0);
        op(cmd_write, 24'h5, 16'h1234);
        op(cmd_read, 24'h5, 16'h0);
        bus(1'b0, reg_rdata, 32'h0, q);
        check(q[15:0], 16'hC0A2);
        $display("test locked write done");
        // enabled write, read back under both select patterns
        bus(1'b1, reg_ctrl, 32'h4, q);
        op(cmd_write, 24'h5, 16'h1234);
        for (int s = 0; s < 2; s++) begin
            bus(1'b1, reg_ctrl, s ? 32'h6 : 32'h4, q);
            op(cmd_read, 24'h5, 16'h0);
            bus(1'b0, reg_rdata, 32'h0, q);
            check(q[15:0], 16'h1234);
        end
        // byte width: each byte on the low lines
        bus(1'b1, reg_ctrl, 32'h1, q);
        for (int b = 0; b < 2; b++) begin
            op(cmd_read, 24'h4 + 24'(b), 16'h0);
            bus(1'b0, reg_rdata, 32'h0, q);
            check(q[7:0], b ? 32'h12 : 32'h34);
        end
        $display("test enabled write done");
        // eight-word mode set, then cleared by a short reset
        bus(1'b1, reg_ctrl, 32'h8, q);
        op(cmd_set_config, 24'h2000, 16'h2000);
        bus(1'b0, reg_status, 32'h0, q);
        check(q[3], 1'b1);
        op(cmd_reset, 24'h0, 16'h0);
        bus(1'b0, reg_status, 32'h0, q);
        check(q[3], 1'b0);
        op(cmd_read, 24'h5, 16'h0);
        bus(1'b0, reg_rdata, 32'h0, q);
        check(q[15:0], 16'h1234);
        $display("test config done");
        test_done();
    end
endmodule
